// ---- src/dtc_timer_counter.sv ----
// Contract
// - cascade: low byte counts, carries into high, high wrap sets flag.
// - setting run bit starts counting and leaves count bytes untouched.
// - source bit zero counts internal cycles, one counts the count pin.
// - timer operation advances once per six timer clock periods.
// - counter samples pin per cycle, counts high-then-low sample pairs.
// - fast select fixes osc/2; else osc/2 standard, osc in double speed.
// - gate clear: run bit alone enables (timer one needs no run bit in split mode); gate set: pin also controls.
// - gated timer counts only while gate pin high and run set (timer one: gate pin alone in split mode).
// - wrap from all ones to zero sets overflow flag, raising request.
// - mode field selects 13-bit, 16-bit, 8-bit reload or split; timer one holds its count in mode 3.
// - mode 0: low five bits prescale by 32 into high byte.
// - mode 2: low byte overflow sets flag, reloads from high byte.
// - overflow flag cleared by hardware when interrupt is serviced.
// - reload value written any time is used at next reload.
// - split mode: timer zero low byte uses timer zero controls.
// - split mode: high byte times, uses timer one run and flag.
// - nonzero divider select divides timer zero overflows by 2 to n.
// - two independently configurable 16-bit timer/counters.
`timescale 1ns/10ps
`include "dtc_cfg.svh"

module dtc_timer_counter
	import dtc_pkg::*;
#(
	parameter int PERIODS = `DTC_PERIPH_PERIODS
)
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStrobe,
	input  wire logic       rdStrobe,
	output logic      [7:0] rdData,
	input  wire logic       doubleSpeedMode,
	input  wire logic       countPinZero,
	input  wire logic       countPinOne,
	input  wire logic       extGatePinZero,
	input  wire logic       extGatePinOne,
	input  wire logic       ackTimerZero,
	input  wire logic       ackTimerOne,
	output logic            timerZeroOverflow,
	output logic            timerOneOverflow
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic       timerZeroRun;
	logic       timerOneRun;
	logic [7:0] timerModeReg;
	logic [1:0] clockConfigReg;
	logic [2:0] timerZeroExtendDivSel;
	logic [7:0] timerZeroLowByte;
	logic [7:0] timerZeroHighByte;
	logic [7:0] timerOneLowByte;
	logic [7:0] timerOneHighByte;
	logic [6:0] divCount;

	logic       wrControl;
	logic       wrZeroLow;
	logic       wrZeroHigh;
	logic       wrOneLow;
	logic       wrOneHigh;
	logic       wrSched;

	assign wrControl  = wrStrobe & (addr == `DTC_ADDR_CONTROL);
	assign wrZeroLow  = wrStrobe & (addr == `DTC_ADDR_ZERO_LOW);
	assign wrZeroHigh = wrStrobe & (addr == `DTC_ADDR_ZERO_HIGH);
	assign wrOneLow   = wrStrobe & (addr == `DTC_ADDR_ONE_LOW);
	assign wrOneHigh  = wrStrobe & (addr == `DTC_ADDR_ONE_HIGH);
	assign wrSched    = wrStrobe & (addr == `DTC_ADDR_SCHED);

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	dtc_mode_t zeroMode;
	dtc_mode_t oneMode;
	logic      zeroSource;
	logic      oneSource;
	logic      zeroGate;
	logic      oneGate;
	logic      zeroSplit;

	assign zeroMode   = dtc_mode_t'(
		timerModeReg[`DTC_MOD_ZERO_MSB:`DTC_MOD_ZERO_LSB]);
	assign oneMode    = dtc_mode_t'(
		timerModeReg[`DTC_MOD_ONE_MSB:`DTC_MOD_ONE_LSB]);
	assign zeroSource = timerModeReg[`DTC_MOD_ZERO_SRC];
	assign oneSource  = timerModeReg[`DTC_MOD_ONE_SRC];
	assign zeroGate   = timerModeReg[`DTC_MOD_ZERO_GATE];
	assign oneGate    = timerModeReg[`DTC_MOD_ONE_GATE];
	assign zeroSplit  = (zeroMode == DTC_MODE_SPLIT);

	// ----------------------------------------
	// cycle ticks and edge detection
	// ----------------------------------------
	logic zeroTick;
	logic oneTick;
	logic zeroEdge;
	logic oneEdge;

	dtc_cycle_gen #(
		.PERIODS         (PERIODS)
	) u_zero_cycle (
		.clk             (clk),
		.reset           (reset),
		.fastClkSel      (clockConfigReg[`DTC_CLK_ZERO_FAST]),
		.doubleSpeedMode (doubleSpeedMode),
		.cycleTick       (zeroTick)
	);

	dtc_cycle_gen #(
		.PERIODS         (PERIODS)
	) u_one_cycle (
		.clk             (clk),
		.reset           (reset),
		.fastClkSel      (clockConfigReg[`DTC_CLK_ONE_FAST]),
		.doubleSpeedMode (doubleSpeedMode),
		.cycleTick       (oneTick)
	);

	dtc_edge_sample u_zero_edge (
		.clk       (clk),
		.reset     (reset),
		.cycleTick (zeroTick),
		.countPin  (countPinZero),
		.fallEdge  (zeroEdge)
	);

	dtc_edge_sample u_one_edge (
		.clk       (clk),
		.reset     (reset),
		.cycleTick (oneTick),
		.countPin  (countPinOne),
		.fallEdge  (oneEdge)
	);

	// ----------------------------------------
	// enables and steps
	// ----------------------------------------
	logic zeroEnable;
	logic oneEnable;
	logic zeroStep;
	logic oneStep;
	logic splitStep;

	assign zeroEnable = timerZeroRun
		& (~zeroGate | extGatePinZero);
	assign oneEnable  = (zeroSplit | timerOneRun)
		& (~oneGate | extGatePinOne);
	assign zeroStep   = zeroEnable & (zeroSource ? zeroEdge : zeroTick);
	assign oneStep    = oneEnable & (oneSource ? oneEdge : oneTick)
		& (oneMode != DTC_MODE_SPLIT);
	assign splitStep  = zeroSplit & timerOneRun & zeroTick;

	// ----------------------------------------
	// timer zero next count
	// ----------------------------------------
	logic [7:0]  next_zeroLow;
	logic [7:0]  next_zeroHigh;
	logic        zeroNativeOvf;
	logic        splitHighOvf;
	logic [15:0] zeroWord;

	assign zeroWord = {timerZeroHighByte, timerZeroLowByte} + 16'h0001;

	always_comb
	begin
		next_zeroLow  = timerZeroLowByte;
		next_zeroHigh = timerZeroHighByte;
		zeroNativeOvf = 1'b0;
		splitHighOvf  = 1'b0;
		if (zeroStep)
		begin
			unique case (zeroMode)
				DTC_MODE_PRESCALED:
				begin
					if (timerZeroLowByte[`DTC_PRESCALE_MSB:0] == `DTC_PRESCALE_TOP)
					begin
						next_zeroLow  = {timerZeroLowByte[7:`DTC_PRESCALE_MSB+1],
							`DTC_PRESCALE_ZERO};
						next_zeroHigh = timerZeroHighByte + 8'h01;
						zeroNativeOvf = (timerZeroHighByte == `DTC_BYTE_TOP);
					end
					else
						next_zeroLow = {timerZeroLowByte[7:`DTC_PRESCALE_MSB+1],
							timerZeroLowByte[`DTC_PRESCALE_MSB:0] + 5'h01};
				end
				DTC_MODE_CASCADE:
				begin
					next_zeroLow  = zeroWord[7:0];
					next_zeroHigh = zeroWord[15:8];
					zeroNativeOvf = ({timerZeroHighByte, timerZeroLowByte}
						== `DTC_WORD_TOP);
				end
				DTC_MODE_RELOAD:
				begin
					if (timerZeroLowByte == `DTC_BYTE_TOP)
					begin
						next_zeroLow  = timerZeroHighByte;
						zeroNativeOvf = 1'b1;
					end
					else
						next_zeroLow = timerZeroLowByte + 8'h01;
				end
				DTC_MODE_SPLIT:
				begin
					next_zeroLow  = timerZeroLowByte + 8'h01;
					zeroNativeOvf = (timerZeroLowByte == `DTC_BYTE_TOP);
				end
			endcase
		end
		if (splitStep)
		begin
			next_zeroHigh = timerZeroHighByte + 8'h01;
			splitHighOvf  = (timerZeroHighByte == `DTC_BYTE_TOP);
		end
	end

	// ----------------------------------------
	// timer one next count
	// ----------------------------------------
	logic [7:0]  next_oneLow;
	logic [7:0]  next_oneHigh;
	logic        oneNativeOvf;
	logic [15:0] oneWord;

	assign oneWord = {timerOneHighByte, timerOneLowByte} + 16'h0001;

	always_comb
	begin
		next_oneLow  = timerOneLowByte;
		next_oneHigh = timerOneHighByte;
		oneNativeOvf = 1'b0;
		if (oneStep)
		begin
			unique case (oneMode)
				DTC_MODE_PRESCALED:
				begin
					if (timerOneLowByte[`DTC_PRESCALE_MSB:0] == `DTC_PRESCALE_TOP)
					begin
						next_oneLow  = {timerOneLowByte[7:`DTC_PRESCALE_MSB+1],
							`DTC_PRESCALE_ZERO};
						next_oneHigh = timerOneHighByte + 8'h01;
						oneNativeOvf = (timerOneHighByte == `DTC_BYTE_TOP);
					end
					else
						next_oneLow = {timerOneLowByte[7:`DTC_PRESCALE_MSB+1],
							timerOneLowByte[`DTC_PRESCALE_MSB:0] + 5'h01};
				end
				DTC_MODE_CASCADE:
				begin
					next_oneLow  = oneWord[7:0];
					next_oneHigh = oneWord[15:8];
					oneNativeOvf = ({timerOneHighByte, timerOneLowByte}
						== `DTC_WORD_TOP);
				end
				DTC_MODE_RELOAD:
				begin
					if (timerOneLowByte == `DTC_BYTE_TOP)
					begin
						next_oneLow  = timerOneHighByte;
						oneNativeOvf = 1'b1;
					end
					else
						next_oneLow = timerOneLowByte + 8'h01;
				end
				DTC_MODE_SPLIT:
				begin
					next_oneLow = timerOneLowByte;
				end
			endcase
		end
	end

	// ----------------------------------------
	// overflow divider for timer zero
	// ----------------------------------------
	logic [6:0] divTarget;
	logic [7:0] divSpan;
	logic       zeroDividedOvf;

	assign divSpan        = `DTC_DIV_ONE << timerZeroExtendDivSel;
	assign divTarget      = 7'(divSpan - `DTC_DIV_ONE);
	assign zeroDividedOvf = zeroNativeOvf & (divCount == divTarget);

	always_ff @(posedge clk)
	begin
		if (reset)
			divCount <= `DTC_RESET_DIV;
		else if (wrSched)
			divCount <= `DTC_RESET_DIV;
		else if (zeroNativeOvf)
			divCount <= zeroDividedOvf ? `DTC_RESET_DIV
				: divCount + 7'h01;
	end

	// ----------------------------------------
	// count bytes
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			timerZeroLowByte  <= `DTC_RESET_BYTE;
			timerZeroHighByte <= `DTC_RESET_BYTE;
			timerOneLowByte   <= `DTC_RESET_BYTE;
			timerOneHighByte  <= `DTC_RESET_BYTE;
		end
		else
		begin
			timerZeroLowByte  <= wrZeroLow  ? wrData : next_zeroLow;
			timerZeroHighByte <= wrZeroHigh ? wrData : next_zeroHigh;
			timerOneLowByte   <= wrOneLow   ? wrData : next_oneLow;
			timerOneHighByte  <= wrOneHigh  ? wrData : next_oneHigh;
		end
	end

	// ----------------------------------------
	// control, mode and clock registers
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			timerZeroRun <= 1'b0;
			timerOneRun  <= 1'b0;
		end
		else if (wrControl)
		begin
			timerZeroRun <= wrData[`DTC_CTL_ZERO_RUN];
			timerOneRun  <= wrData[`DTC_CTL_ONE_RUN];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			timerModeReg          <= `DTC_RESET_BYTE;
			clockConfigReg        <= `DTC_RESET_CLKCFG;
			timerZeroExtendDivSel <= `DTC_RESET_SCHED;
		end
		else if (wrStrobe)
		begin
			if (addr == `DTC_ADDR_MODE)
				timerModeReg <= wrData;
			if (addr == `DTC_ADDR_CLKCFG)
				clockConfigReg <= wrData[1:0];
			if (wrSched)
				timerZeroExtendDivSel <= wrData[`DTC_SCHED_MSB:`DTC_SCHED_LSB];
		end
	end

	// ----------------------------------------
	// overflow flags, set wins over clear
	// ----------------------------------------
	logic zeroFlagSet;
	logic oneFlagSet;

	assign zeroFlagSet = zeroDividedOvf;
	assign oneFlagSet  = zeroSplit ? splitHighOvf : oneNativeOvf;

	always_ff @(posedge clk)
	begin
		if (reset)
			timerZeroOverflow <= 1'b0;
		else if (zeroFlagSet)
			timerZeroOverflow <= 1'b1;
		else if (wrControl)
			timerZeroOverflow <= wrData[`DTC_CTL_ZERO_OVF];
		else if (ackTimerZero)
			timerZeroOverflow <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			timerOneOverflow <= 1'b0;
		else if (oneFlagSet)
			timerOneOverflow <= 1'b1;
		else if (wrControl)
			timerOneOverflow <= wrData[`DTC_CTL_ONE_OVF];
		else if (ackTimerOne)
			timerOneOverflow <= 1'b0;
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			rdData <= `DTC_RESET_BYTE;
		else if (rdStrobe)
		begin
			unique case (addr)
				`DTC_ADDR_CONTROL:
					rdData <= {timerOneOverflow, timerOneRun,
						timerZeroOverflow, timerZeroRun, 4'h0};
				`DTC_ADDR_MODE:      rdData <= timerModeReg;
				`DTC_ADDR_ZERO_LOW:  rdData <= timerZeroLowByte;
				`DTC_ADDR_ZERO_HIGH: rdData <= timerZeroHighByte;
				`DTC_ADDR_ONE_LOW:   rdData <= timerOneLowByte;
				`DTC_ADDR_ONE_HIGH:  rdData <= timerOneHighByte;
				`DTC_ADDR_CLKCFG:    rdData <= {6'h00, clockConfigReg};
				`DTC_ADDR_SCHED:     rdData <= {5'h00, timerZeroExtendDivSel};
				default:             rdData <= `DTC_RESET_BYTE;
			endcase
		end
		else
			rdData <= `DTC_RESET_BYTE;
	end

endmodule : dtc_timer_counter

// ---- inc/dtc_cfg.svh ----
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define DTC_ADDR_CONTROL   8'h88
`define DTC_ADDR_MODE      8'h89
`define DTC_ADDR_ZERO_LOW  8'h8a
`define DTC_ADDR_ONE_LOW   8'h8b
`define DTC_ADDR_ZERO_HIGH 8'h8c
`define DTC_ADDR_ONE_HIGH  8'h8d
`define DTC_ADDR_CLKCFG    8'h8e
`define DTC_ADDR_SCHED     8'h8f

// ----------------------------------------
// control register bit positions
// ----------------------------------------
`define DTC_CTL_ONE_OVF    7
`define DTC_CTL_ONE_RUN    6
`define DTC_CTL_ZERO_OVF   5
`define DTC_CTL_ZERO_RUN   4

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define DTC_MOD_ZERO_MSB   1
`define DTC_MOD_ZERO_LSB   0
`define DTC_MOD_ZERO_SRC   2
`define DTC_MOD_ZERO_GATE  3
`define DTC_MOD_ONE_MSB    5
`define DTC_MOD_ONE_LSB    4
`define DTC_MOD_ONE_SRC    6
`define DTC_MOD_ONE_GATE   7

// ----------------------------------------
// clock config and divider fields
// ----------------------------------------
`define DTC_CLK_ZERO_FAST  0
`define DTC_CLK_ONE_FAST   1
`define DTC_SCHED_MSB      2
`define DTC_SCHED_LSB      0

// ----------------------------------------
// reset values and counting constants
// ----------------------------------------
`define DTC_RESET_BYTE     8'h00
`define DTC_RESET_CLKCFG   2'h0
`define DTC_RESET_SCHED    3'h0
`define DTC_RESET_DIV      7'h00
`define DTC_BYTE_TOP       8'hff
`define DTC_WORD_TOP       16'hffff
`define DTC_PRESCALE_TOP   5'h1f
`define DTC_PRESCALE_ZERO  5'h00
`define DTC_PRESCALE_MSB   4
`define DTC_PERIPH_PERIODS 6
`define DTC_DIV_ONE        8'h01

`endif

// ---- inc/dtc_pkg.sv ----
package dtc_pkg;

	// ----------------------------------------
	// operating modes
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		DTC_MODE_PRESCALED = 2'h0,
		DTC_MODE_CASCADE   = 2'h1,
		DTC_MODE_RELOAD    = 2'h2,
		DTC_MODE_SPLIT     = 2'h3
	} dtc_mode_t;

endpackage : dtc_pkg

// ---- src/dtc_cycle_gen.sv ----
`timescale 1ns/10ps
`include "dtc_cfg.svh"

module dtc_cycle_gen
	import dtc_pkg::*;
#(
	parameter int PERIODS = `DTC_PERIPH_PERIODS
)
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic fastClkSel,
	input  wire logic doubleSpeedMode,
	output logic      cycleTick
);

	// ----------------------------------------
	// timer clock and peripheral cycle
	// ----------------------------------------
	localparam int CW = $clog2(PERIODS);

	logic          halfPhase;
	logic          halfNeeded;
	logic          timerClkEn;
	logic [CW-1:0] periodCount;

	assign halfNeeded = fastClkSel | ~doubleSpeedMode;
	assign timerClkEn = halfNeeded ? halfPhase : 1'b1;

	always_ff @(posedge clk)
	begin
		if (reset)
			halfPhase <= 1'b0;
		else
			halfPhase <= ~halfPhase;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			periodCount <= '0;
			cycleTick   <= 1'b0;
		end
		else
		begin
			cycleTick <= 1'b0;
			if (timerClkEn)
			begin
				if (periodCount == CW'(PERIODS - 1))
				begin
					periodCount <= '0;
					cycleTick   <= 1'b1;
				end
				else
					periodCount <= periodCount + CW'(1);
			end
		end
	end

endmodule : dtc_cycle_gen

// ---- src/dtc_edge_sample.sv ----
`timescale 1ns/10ps
`include "dtc_cfg.svh"

module dtc_edge_sample
	import dtc_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic cycleTick,
	input  wire logic countPin,
	output logic      fallEdge
);

	// ----------------------------------------
	// per-cycle sampling of the count pin
	// ----------------------------------------
	logic lastSample;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lastSample <= 1'b0;
			fallEdge   <= 1'b0;
		end
		else
		begin
			fallEdge <= 1'b0;
			if (cycleTick)
			begin
				lastSample <= countPin;
				fallEdge   <= lastSample & ~countPin;
			end
		end
	end

endmodule : dtc_edge_sample

// ---- verif/dtc_pin_model.sv ----
`timescale 1ns/10ps

module dtc_pin_model
#(
	parameter int HOLD = 8
)
(
	input  wire logic clk,
	output logic      countPinZero,
	output logic      countPinOne,
	output logic      extGatePinZero,
	output logic      extGatePinOne
);
	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	initial
	begin
		countPinZero   = 1'b0;
		countPinOne    = 1'b0;
		extGatePinZero = 1'b0;
		extGatePinOne  = 1'b0;
	end

	task pulses(input int n);
		for (int i = 0; i < n; i++)
		begin
			repeat (HOLD) @(posedge clk);
			countPinZero <= 1'b1;
			countPinOne  <= 1'b1;
			repeat (HOLD) @(posedge clk);
			countPinZero <= 1'b0;
			countPinOne  <= 1'b0;
		end
	endtask : pulses

	task gate(input logic g);
		@(posedge clk);
		extGatePinZero <= g;
		extGatePinOne  <= g;
	endtask : gate
endmodule : dtc_pin_model

// ---- verif/dtc_timer_counter_sva.sv ----
`timescale 1ns/10ps

module dtc_timer_counter_sva
	import dtc_pkg::*;
#(
	parameter int PERIODS = 6
)
(
	input wire logic       clk,
	input wire logic       reset,
	input wire logic [7:0] addr,
	input wire logic [7:0] wrData,
	input wire logic       wrStrobe,
	input wire logic       rdStrobe,
	input wire logic [7:0] rdData,
	input wire logic       ackTimerZero,
	input wire logic       ackTimerOne,
	input wire logic       timerZeroOverflow,
	input wire logic       timerOneOverflow
);
	// ----------------------------------------
	// run bit shadow
	// ----------------------------------------
	logic [1:0] runBits;

	always_ff @(posedge clk)
	begin
		if (reset)
			runBits <= 2'h0;
		else if (wrStrobe && addr == 8'h88)
			runBits <= {wrData[6], wrData[4]};
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_ctlRead;
		rdStrobe && addr == 8'h88;
	endsequence
	sequence s_stop;
		wrStrobe && addr == 8'h88 && wrData == 8'h00;
	endsequence
	sequence s_presetRead;
		wrStrobe && addr == 8'h8c ##2
		rdStrobe && addr == 8'h8c && runBits == 2'h0;
	endsequence

	chk_read_idle:
	assert property (!$past(rdStrobe) |-> rdData == 8'h00)
		else $error("read data not zero outside a read");
	chk_ctl_low_zero:
	assert property (s_ctlRead |=> rdData[3:0] == 4'h0)
		else $error("control low bits not zero");
	chk_unmapped_zero:
	assert property (rdStrobe && (addr < 8'h88 || addr > 8'h8f)
		|=> rdData == 8'h00) else $error("unmapped read not zero");
	chk_flag_read:
	assert property (s_ctlRead |=> rdData[7] == $past(timerOneOverflow)
		&& rdData[5] == $past(timerZeroOverflow))
		else $error("flags read back wrong");
	chk_zero_fall_cause:
	assert property ($fell(timerZeroOverflow) |-> $past(ackTimerZero)
		|| ($past(wrStrobe) && $past(addr) == 8'h88))
		else $error("timer zero flag cleared without cause");
	chk_one_fall_cause:
	assert property ($fell(timerOneOverflow) |-> $past(ackTimerOne)
		|| ($past(wrStrobe) && $past(addr) == 8'h88))
		else $error("timer one flag cleared without cause");
	chk_sw_flag_set:
	assert property (wrStrobe && addr == 8'h88 && wrData[5]
		&& !ackTimerZero |=> timerZeroOverflow)
		else $error("written flag not set");
	chk_stop_quiet:
	assert property (s_stop |-> ##2 (!$rose(timerZeroOverflow)
		&& !$rose(timerOneOverflow)) [*4])
		else $error("flag raised while stopped");
	chk_preset_hold:
	assert property (s_presetRead |=> rdData == $past(wrData, 3))
		else $error("preset value not held");
endmodule : dtc_timer_counter_sva

bind dtc_timer_counter dtc_timer_counter_sva #(.PERIODS(PERIODS))
	i_dtc_timer_counter_sva
(
	.clk              (clk),
	.reset            (reset),
	.addr             (addr),
	.wrData           (wrData),
	.wrStrobe         (wrStrobe),
	.rdStrobe         (rdStrobe),
	.rdData           (rdData),
	.ackTimerZero     (ackTimerZero),
	.ackTimerOne      (ackTimerOne),
	.timerZeroOverflow(timerZeroOverflow),
	.timerOneOverflow (timerOneOverflow)
);

// ---- verif/tb_dtc_timer_counter.sv ----
`timescale 1ns/10ps

module tb_dtc_timer_counter;
	localparam int P  = 2;
	localparam int TK = 2 * P;

	logic       clk;
	logic       reset;
	logic [7:0] addr;
	logic [7:0] wrData;
	logic       wrStrobe;
	logic       rdStrobe;
	logic [7:0] rdData;
	logic       doubleSpeedMode;
	logic       countPinZero;
	logic       countPinOne;
	logic       extGatePinZero;
	logic       extGatePinOne;
	logic       ackTimerZero;
	logic       ackTimerOne;
	logic       timerZeroOverflow;
	logic       timerOneOverflow;
	int         failCount = 0;
	int         numChecks = 0;
	int         cycles    = 0;

	dtc_timer_counter #(.PERIODS(P)) i_dtc_timer_counter
	(
		.clk              (clk),
		.reset            (reset),
		.addr             (addr),
		.wrData           (wrData),
		.wrStrobe         (wrStrobe),
		.rdStrobe         (rdStrobe),
		.rdData           (rdData),
		.doubleSpeedMode  (doubleSpeedMode),
		.countPinZero     (countPinZero),
		.countPinOne      (countPinOne),
		.extGatePinZero   (extGatePinZero),
		.extGatePinOne    (extGatePinOne),
		.ackTimerZero     (ackTimerZero),
		.ackTimerOne      (ackTimerOne),
		.timerZeroOverflow(timerZeroOverflow),
		.timerOneOverflow (timerOneOverflow)
	);

	dtc_pin_model #(.HOLD(2 * TK)) i_dtc_pin_model
	(
		.clk           (clk),
		.countPinZero  (countPinZero),
		.countPinOne   (countPinOne),
		.extGatePinZero(extGatePinZero),
		.extGatePinOne (extGatePinOne)
	);

	// ----------------------------------------
	// clock, timeout and verdict
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failCount++;
			endSim();
		end
	end

	task endSim;
		if (failCount == 0 && numChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : endSim

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			failCount++;
			$display("wrong value %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk

	// ----------------------------------------
	// bus and timing helpers
	// ----------------------------------------
	task wr(input logic [7:0] a, input logic [7:0] d);
		addr     <= a;
		wrData   <= d;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
		@(posedge clk);
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] d);
		addr     <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1 d = rdData;
		@(posedge clk);
	endtask : rd

	task waitFlag(input bit one, input int lim, output int n);
		n = 0;
		#1;
		while ((one ? timerOneOverflow : timerZeroOverflow) !== 1'b1
			&& n < lim)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
	endtask : waitFlag

	task timeIt(input logic [7:0] md, lo, hi, ctl, input int s, tk);
		int n;
		wr(8'h89, md);
		wr(8'h8a, lo);
		wr(8'h8c, hi);
		wr(8'h88, ctl);
		waitFlag(1'b0, s * tk + 8, n);
		chk("period", 16'(n >= (s - 1) * tk - 2 && n <= s * tk + 2),
			16'h1);
	endtask : timeIt

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task tReset;
		logic [7:0] d;
		for (int a = 8'h88; a <= 8'h90; a++)
		begin
			rd(a[7:0], d);
			chk("reset value", d, 8'h00);
		end
		wr(8'h88, 8'ha0);
		rd(8'h88, d);
		chk("flag write", d, 8'ha0);
		wr(8'h88, 8'h00);
		wr(8'h8a, 8'h5a);
		wr(8'h8c, 8'ha5);
		rd(8'h8c, d);
		chk("preset", d, 8'ha5);
		wr(8'h89, 8'h01);
		wr(8'h88, 8'h10);
		rd(8'h8a, d);
		chk("run keeps", 16'(d == 8'h5a || d == 8'h5b), 16'h1);
		wr(8'h88, 8'h00);
	endtask : tReset

	task tCascade;
		logic [7:0] d;
		timeIt(8'h01, 8'hff, 8'hfe, 8'h10, 257, TK);
		wr(8'h88, 8'h00);
		rd(8'h8a, d);
		chk("low after wrap", d, 8'h00);
		rd(8'h8c, d);
		chk("high after wrap", d, 8'h00);
	endtask : tCascade

	task tPrescale;
		logic [7:0] d;
		timeIt(8'h00, 8'h3e, 8'hff, 8'h10, 2, TK);
		wr(8'h88, 8'h00);
		rd(8'h8c, d);
		chk("prescaled high", d, 8'h00);
		rd(8'h8a, d);
		chk("prescaler bits", d[4:0], 8'h00);
	endtask : tPrescale

	task tReload;
		logic [7:0] d;
		int n;
		timeIt(8'h02, 8'hfe, 8'hf0, 8'h10, 2, TK);
		ackTimerZero <= 1'b1;
		@(posedge clk);
		ackTimerZero <= 1'b0;
		#1 chk("ack clears", timerZeroOverflow, 16'h0);
		@(posedge clk);
		wr(8'h8c, 8'hfa);
		waitFlag(1'b0, 16 * TK + 8, n);
		wr(8'h88, 8'h00);
		rd(8'h8a, d);
		chk("new reload", d, 8'hfa);
		rd(8'h8c, d);
		chk("reload source", d, 8'hfa);
	endtask : tReload

	task tSplit;
		int n;
		timeIt(8'h03, 8'hff, 8'hff, 8'h10, 1, TK);
		#1 chk("high idle", timerOneOverflow, 16'h0);
		@(posedge clk);
		wr(8'h88, 8'h50);
		waitFlag(1'b1, TK + 8, n);
		chk("high wrap", 16'(n <= TK + 2), 16'h1);
		ackTimerOne <= 1'b1;
		@(posedge clk);
		ackTimerOne <= 1'b0;
		#1 chk("ack one", timerOneOverflow, 16'h0);
		@(posedge clk);
		wr(8'h88, 8'h00);
	endtask : tSplit

	task tCounter;
		logic [7:0] d;
		i_dtc_pin_model.gate(1'b0);
		wr(8'h89, 8'h5d);
		wr(8'h8a, 8'h00);
		wr(8'h8b, 8'h00);
		wr(8'h88, 8'h50);
		i_dtc_pin_model.pulses(5);
		repeat (4 * TK) @(posedge clk);
		wr(8'h88, 8'h00);
		rd(8'h8b, d);
		chk("event count", d, 8'h05);
		rd(8'h8a, d);
		chk("gated count", d, 8'h00);
		i_dtc_pin_model.gate(1'b1);
		wr(8'h89, 8'h59);
		wr(8'h88, 8'h10);
		repeat (10 * TK) @(posedge clk);
		wr(8'h88, 8'h00);
		rd(8'h8a, d);
		chk("open gate", 16'(d >= 8'h09 && d <= 8'h0b), 16'h1);
		wr(8'h89, 8'h5d);
		wr(8'h8a, 8'h00);
		wr(8'h88, 8'h10);
		i_dtc_pin_model.pulses(3);
		repeat (4 * TK) @(posedge clk);
		wr(8'h88, 8'h00);
		rd(8'h8a, d);
		chk("pin count zero", d, 8'h03);
	endtask : tCounter

	task tOne;
		logic [7:0] d;
		int n;
		wr(8'h8e, 8'h02);
		wr(8'h89, 8'ha0);
		wr(8'h8b, 8'hfe);
		wr(8'h8d, 8'hf0);
		wr(8'h88, 8'h40);
		waitFlag(1'b1, 2 * TK + 8, n);
		chk("one reload", 16'(n >= TK - 2 && n <= 2 * TK + 2),
			16'h1);
		wr(8'h88, 8'h00);
		rd(8'h8b, d);
		chk("one low", d, 8'hf0);
		wr(8'h89, 8'h30);
		wr(8'h88, 8'h40);
		repeat (4 * TK) @(posedge clk);
		wr(8'h88, 8'h00);
		rd(8'h8b, d);
		chk("one halted", d, 8'hf0);
	endtask : tOne

	task tDouble;
		doubleSpeedMode <= 1'b1;
		wr(8'h8e, 8'h00);
		timeIt(8'h01, 8'he0, 8'hff, 8'h10, 32, P);
		wr(8'h88, 8'h00);
		wr(8'h8e, 8'h01);
		timeIt(8'h01, 8'he0, 8'hff, 8'h10, 32, TK);
		wr(8'h88, 8'h00);
		doubleSpeedMode <= 1'b0;
	endtask : tDouble

	task tDivider;
		for (int k = 0; k < 8; k++)
		begin
			wr(8'h8f, 8'(k));
			timeIt(8'h02, 8'hff, 8'hff, 8'h10, 1 << k, TK);
			wr(8'h88, 8'h00);
		end
		wr(8'h8f, 8'h00);
	endtask : tDivider

	initial
	begin
		reset           = 1'b1;
		addr            = 8'h00;
		wrData          = 8'h00;
		wrStrobe        = 1'b0;
		rdStrobe        = 1'b0;
		doubleSpeedMode = 1'b0;
		ackTimerZero    = 1'b0;
		ackTimerOne     = 1'b0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		tReset();
		tCascade();
		tPrescale();
		tReload();
		tSplit();
		tCounter();
		tDouble();
		tDivider();
		tOne();
		endSim();
	end
endmodule : tb_dtc_timer_counter
